// ---- sbp_pkg.sv ----
package sbp_pkg;
    localparam int ADDR_W = 22;
    localparam int IADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int ROM_ADDR_LSB = 1;
    localparam int OTH_ADDR_LSB = 0;
    localparam int PIN_COUNT = 6;
    // Pin function select bit positions
    localparam int PIN_RD = 0;
    localparam int PIN_WR = 1;
    localparam int PIN_RDY = 2;
    localparam int PIN_WIDE = 3;
    localparam int PIN_UBE = 4;
    localparam int PIN_RST = 5;
    // Timing
    localparam int SETUP_CYCLES = 1;
    localparam logic [7:0] SYSTEM_BUS_CLOCK_DIV_RESET = 8'h02;
    localparam logic [1:0] PCLK_DIV_RESET = 2'h1;

    typedef enum logic [1:0] {
        SBP_TGT_SDRAM = 2'b00,
        SBP_TGT_ROM = 2'b01,
        SBP_TGT_IO = 2'b10,
        SBP_TGT_MEM = 2'b11
    } sbp_target_e;

    typedef enum logic [2:0] {
        SBP_IDLE = 3'b000,
        SBP_SETUP = 3'b001,
        SBP_STROBE = 3'b010,
        SBP_SDRAM = 3'b011,
        SBP_DONE = 3'b100
    } sbp_state_e;

    typedef struct packed {
        logic valid;
        logic write;
        sbp_target_e target;
        logic [IADDR_W-1:0] addr;
        logic [1:0] byte_en;
        logic [DATA_W-1:0] wdata;
    } sbp_req_s;

    typedef struct packed {
        logic done;
        logic wide;
        logic [DATA_W-1:0] rdata;
    } sbp_rsp_s;
endpackage

// ---- sbp_clk_gate.sv ----
`timescale 1ns/1ps
// Divided, gated clock: toggles only while run is high, idles low.
module sbp_clk_gate (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic run,
    input wire logic [7:0] div,
    output logic clk_out
);
    logic [7:0] cnt_q;
    logic clk_q;
    wire terminal = (cnt_q >= div);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 8'h00;
            clk_q <= 1'b0;
        end else if (!run) begin
            cnt_q <= 8'h00;
            clk_q <= 1'b0;
        end else if (terminal) begin
            cnt_q <= 8'h00;
            clk_q <= ~clk_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign clk_out = clk_q;
endmodule

// ---- sbp_bus_port.sv ----
`timescale 1ns/1ps
module sbp_bus_port (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic internal_bus_clock,
    input sbp_pkg::sbp_req_s req,
    output logic req_ready,
    output sbp_pkg::sbp_rsp_s rsp,
    input wire logic bus_reset_req,
    input wire logic [sbp_pkg::PIN_COUNT-1:0] pin_bus_sel,
    input wire logic [sbp_pkg::PIN_COUNT-1:0] gpio_out,
    input wire logic [sbp_pkg::PIN_COUNT-1:0] gpio_oe,
    output logic [sbp_pkg::PIN_COUNT-1:0] gpio_in,
    input wire logic [7:0] system_bus_clock_div,
    output logic [sbp_pkg::ADDR_W-1:0] addr_out,
    input wire logic [sbp_pkg::DATA_W-1:0] data_in,
    output logic [sbp_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic sdram_clock_out,
    output logic system_bus_clock,
    input wire logic [sbp_pkg::PIN_COUNT-1:0] ctl_in,
    output logic [sbp_pkg::PIN_COUNT-1:0] ctl_out,
    output logic [sbp_pkg::PIN_COUNT-1:0] ctl_oe
);
    sbp_pkg::sbp_state_e state_q, state_d;
    sbp_pkg::sbp_req_s cur_q;
    logic [sbp_pkg::ADDR_W-1:0] addr_q;
    logic [sbp_pkg::DATA_W-1:0] rdata_q;
    logic wide_q;
    logic done_q;
    logic rd_n_q, wr_n_q, ube_n_q, rst_n_q;
    logic sdram_run_q, isa_run_q;
    logic oe_q;

    // Pin-side inputs honoured only when the pin is in bus mode
    wire ready_pin = pin_bus_sel[sbp_pkg::PIN_RDY] ? ctl_in[sbp_pkg::PIN_RDY] : 1'b1;
    wire wide_pin = pin_bus_sel[sbp_pkg::PIN_WIDE]
                    & ~ctl_in[sbp_pkg::PIN_WIDE];
    wire is_rom = (req.target == sbp_pkg::SBP_TGT_ROM);
    wire is_sdram = (req.target == sbp_pkg::SBP_TGT_SDRAM);
    wire is_ext = (req.target == sbp_pkg::SBP_TGT_IO) || (req.target == sbp_pkg::SBP_TGT_MEM);
    wire cur_io = (cur_q.target == sbp_pkg::SBP_TGT_IO);
    wire [sbp_pkg::ADDR_W-1:0] rom_addr =
        req.addr[sbp_pkg::ADDR_W:sbp_pkg::ROM_ADDR_LSB];
    wire [sbp_pkg::ADDR_W-1:0] oth_addr =
        req.addr[sbp_pkg::ADDR_W-1:sbp_pkg::OTH_ADDR_LSB];
    wire [sbp_pkg::ADDR_W-1:0] addr_sel = is_rom ? rom_addr : oth_addr;
    wire start = req.valid && (state_q == sbp_pkg::SBP_IDLE);

    always_comb begin
        state_d = state_q;
        case (state_q)
            sbp_pkg::SBP_IDLE: begin
                if (req.valid) begin
                    state_d = is_sdram ? sbp_pkg::SBP_SDRAM : sbp_pkg::SBP_SETUP;
                end
            end
            sbp_pkg::SBP_SETUP: begin
                state_d = sbp_pkg::SBP_STROBE;
            end
            sbp_pkg::SBP_STROBE: begin
                // Wait states while the target holds ready low
                if (ready_pin) begin
                    state_d = sbp_pkg::SBP_DONE;
                end
            end
            sbp_pkg::SBP_SDRAM: begin
                state_d = sbp_pkg::SBP_DONE;
            end
            sbp_pkg::SBP_DONE: begin
                state_d = sbp_pkg::SBP_IDLE;
            end
            default: begin
                state_d = sbp_pkg::SBP_IDLE;
            end
        endcase
    end

    wire enter_strobe = (state_q == sbp_pkg::SBP_SETUP);
    wire leave_strobe = (state_q == sbp_pkg::SBP_STROBE) && ready_pin;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= sbp_pkg::SBP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cur_q <= '0;
            addr_q <= '0;
            oe_q <= 1'b0;
        end else if (start) begin
            cur_q <= req;
            addr_q <= addr_sel;
            oe_q <= req.write;
        end else if (state_q == sbp_pkg::SBP_DONE) begin
            oe_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            ube_n_q <= 1'b1;
        end else if (enter_strobe) begin
            // For IO targets one strobe is chosen from the write flag; other targets assert neither
            rd_n_q <= ~(cur_io & ~cur_q.write);
            wr_n_q <= ~(cur_io & cur_q.write);
            ube_n_q <= ~cur_q.byte_en[1];
        end else if (leave_strobe) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            ube_n_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= '0;
            wide_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == sbp_pkg::SBP_DONE);
            if (leave_strobe && !cur_q.write) begin
                rdata_q <= data_in;
            end
            if (leave_strobe) begin
                wide_q <= wide_pin;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rst_n_q <= 1'b0;
            sdram_run_q <= 1'b0;
            isa_run_q <= 1'b0;
        end else begin
            rst_n_q <= ~bus_reset_req;
            sdram_run_q <= (state_d == sbp_pkg::SBP_SDRAM);
            isa_run_q <= (state_d == sbp_pkg::SBP_SETUP) ||
                         (state_d == sbp_pkg::SBP_STROBE);
        end
    end

    // Gated copy of the internal bus clock; latch-free AND keeps rate equal
    assign sdram_clock_out = internal_bus_clock & sdram_run_q;

    sbp_clk_gate u_system_bus_clock (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(isa_run_q & (cur_q.target != sbp_pkg::SBP_TGT_ROM)),
        .div(system_bus_clock_div),
        .clk_out(system_bus_clock)
    );

    // Strobe pin values in bus mode, index order RD WR RDY WIDE UBE RST
    wire [sbp_pkg::PIN_COUNT-1:0] bus_val = {rst_n_q, ube_n_q, 1'b1, 1'b1, wr_n_q, rd_n_q};
    wire [sbp_pkg::PIN_COUNT-1:0] bus_drv = 6'h33;

    genvar gi;
    generate
        for (gi = 0; gi < sbp_pkg::PIN_COUNT; gi++) begin : g_pin
            assign ctl_out[gi] = pin_bus_sel[gi] ? bus_val[gi] : gpio_out[gi];
            assign ctl_oe[gi] = pin_bus_sel[gi] ? bus_drv[gi] : gpio_oe[gi];
            assign gpio_in[gi] = pin_bus_sel[gi] ? 1'b0 : ctl_in[gi];
        end
    endgenerate

    assign addr_out = addr_q;
    assign data_out = cur_q.wdata;
    assign data_oe = oe_q;
    assign req_ready = (state_q == sbp_pkg::SBP_IDLE);
    assign rsp.done = done_q;
    assign rsp.wide = wide_q;
    assign rsp.rdata = rdata_q;
endmodule

// ---- sbp_bus_port_props.sv ----
`timescale 1ns/1ps
module sbp_bus_port_props (
    input wire logic sys_clk,
    input wire logic reset,
    input sbp_pkg::sbp_req_s req,
    input wire logic req_ready,
    input wire logic bus_reset_req,
    input wire logic [5:0] pin_bus_sel,
    input wire logic [5:0] gpio_out,
    input wire logic [5:0] gpio_oe,
    input wire logic [21:0] addr_out,
    input wire logic sdram_clock_out,
    input wire logic [5:0] ctl_out,
    input wire logic [5:0] ctl_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic take;
    assign take = req.valid && req_ready;
    // Strobe pin index equals the write flag
    sequence io_take(w);
        take && req.target == sbp_pkg::SBP_TGT_IO && req.write == w && pin_bus_sel[w];
    endsequence
    chk_no_overlap: assert property (&pin_bus_sel[1:0] |-> ctl_out[0] || ctl_out[1])
        else $error("both strobes low");
    chk_rd_strobe: assert property (io_take(1'b0) |-> ##[1:3] !ctl_out[0])
        else $error("read strobe missing");
    chk_wr_strobe: assert property (io_take(1'b1) |-> ##[1:3] !ctl_out[1])
        else $error("write strobe missing");
    chk_ube_low: assert property (io_take(req.write) ##0 req.byte_en[1] && pin_bus_sel[4]
        |-> ##[1:3] !ctl_out[4]) else $error("upper enable missing");
    chk_rom_addr: assert property (take && req.target == sbp_pkg::SBP_TGT_ROM
        |=> addr_out == $past(req.addr[22:1])) else $error("rom address");
    chk_other_addr: assert property (take && req.target != sbp_pkg::SBP_TGT_ROM
        |=> addr_out == $past(req.addr[21:0])) else $error("address");
    chk_sdram_clock_out_idle: assert property (req_ready && $past(req_ready) |-> !sdram_clock_out)
        else $error("sdram clock runs idle");
    chk_bus_reset: assert property (pin_bus_sel[5] && bus_reset_req ##1 pin_bus_sel[5]
        |-> !ctl_out[5]) else $error("bus reset not driven");
    chk_gpio_pass: assert property (pin_bus_sel == 0 && $past(pin_bus_sel) == 0
        && $stable(gpio_out) && $stable(gpio_oe) |-> ctl_out == gpio_out && ctl_oe == gpio_oe)
        else $error("gpio not passed");
endmodule

// ---- sbp_far_agent.sv ----
`timescale 1ns/1ps
module sbp_far_agent (
    input wire logic sys_clk,
    input wire logic [5:0] ctl_out,
    input wire logic [5:0] ctl_oe,
    input wire logic [3:0] delay,
    input wire logic wide,
    input wire logic [15:0] rdata,
    output logic [5:0] ctl_in,
    output logic [15:0] data_in
);
    logic rd_act;
    logic act;
    logic [3:0] cnt_q;
    logic [15:0] last_q;
    logic [5:0] far;
    assign rd_act = ctl_oe[0] && !ctl_out[0];
    assign act = rd_act || (ctl_oe[1] && !ctl_out[1]);
    // Pulled-up lines read high when nobody drives them
    assign far = {2'b11, !(act && wide), !act || cnt_q >= delay, 2'b11};
    assign ctl_in = (ctl_oe & ctl_out) | (~ctl_oe & far);
    // Released data bus shows no stale value
    assign data_in = rd_act ? rdata : ~last_q;
    always_ff @(posedge sys_clk) begin
        cnt_q <= act ? cnt_q + 4'h1 : 4'h0;
        last_q <= data_in;
    end
endmodule

// ---- sbp_bus_port_bench.sv ----
`timescale 1ns/1ps
module sbp_bus_port_bench;
    logic sys_clk = 0, reset = 1, ibc = 0, bus_reset_req = 0, wide = 0;
    logic data_oe, sdram_clock_out, system_bus_clock, req_ready;
    sbp_pkg::sbp_req_s req = '0;
    sbp_pkg::sbp_rsp_s rsp;
    logic [5:0] sel = 6'h3F, gpio_out = 6'h00, gpio_oe = 6'h00, gpio_in, ctl_in, ctl_out, ctl_oe;
    logic [7:0] div = 8'h00;
    logic [21:0] addr_out;
    logic [15:0] data_in, data_out, rdata = 16'h0000;
    logic [3:0] delay = 4'h0;
    int fail_count = 0, checks = 0, sd_n = 0, sb_n = 0;
    initial forever #10 sys_clk = ~sys_clk;
    initial forever #5 ibc = ~ibc;
    always @(posedge sdram_clock_out) sd_n++;
    always @(posedge system_bus_clock) sb_n++;
    sbp_bus_port DUT (.sys_clk, .reset, .internal_bus_clock(ibc), .req, .req_ready, .rsp,
        .bus_reset_req, .pin_bus_sel(sel), .gpio_out, .gpio_oe, .gpio_in, .system_bus_clock_div(div),
        .addr_out, .data_in, .data_out, .data_oe, .sdram_clock_out, .system_bus_clock,
        .ctl_in, .ctl_out, .ctl_oe);
    sbp_far_agent far (.sys_clk, .ctl_out, .ctl_oe, .delay, .wide, .rdata, .ctl_in, .data_in);
    task summarize;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [21:0] exp_addr(sbp_pkg::sbp_req_s r);
        return r.target == sbp_pkg::SBP_TGT_ROM ? r.addr[22:1] : r.addr[21:0];
    endfunction
    task xfer(input sbp_pkg::sbp_req_s r);
        int n;
        r.valid = 1'b1;
        sd_n = 0;
        sb_n = 0;
        req = r;
        @(negedge sys_clk);
        req.valid = 1'b0;
        cmp("addr", exp_addr(r), addr_out);
        n = 0;
        while (rsp.done !== 1'b1 && n < 60) begin
            if (ctl_out[1] === 1'b0) begin
                cmp("wdata", r.wdata, data_out);
                cmp("data_oe", 1, data_oe);
            end
            if (ctl_out[0] === 1'b0 || ctl_out[1] === 1'b0)
                cmp("ube", !r.byte_en[1], ctl_out[4]);
            @(negedge sys_clk);
            n++;
        end
        if (n == 60) begin
            fail_count++;
            summarize();
        end
        if (r.target == sbp_pkg::SBP_TGT_IO) begin
            if (!r.write)
                cmp("rdata", rdata, rsp.rdata);
            cmp("wide", sel[3] & wide, rsp.wide);
            cmp("cycles", sel[2] ? delay + 3 : 3, n);
        end
        // One sys_clk cycle of gating holds two internal bus clock periods
        cmp("sdram_clock_out", r.target == sbp_pkg::SBP_TGT_SDRAM ? 2 : 0, sd_n);
        if (r.target != sbp_pkg::SBP_TGT_MEM)
            cmp("system_bus_clock", r.target == sbp_pkg::SBP_TGT_IO, sb_n > 0);
    endtask
    initial begin
        sbp_pkg::sbp_req_s r;
        void'($urandom(32'h393129FF));
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 0;
        cmp("idle strobes", 2'b11, ctl_out[1:0]);
        for (int i = 0; i < 48; i++) begin
            r = '0;
            r.write = 1'($urandom);
            r.target = sbp_pkg::sbp_target_e'(i % 4);
            // First eight transfers (two passes over the four targets) hit the all-ones address boundary
            r.addr = (i < 8) ? '1 : 23'($urandom);
            r.byte_en = 2'($urandom);
            r.wdata = 16'($urandom);
            sel[3:2] = 2'($urandom);
            delay = 4'($urandom_range(5));
            wide = 1'($urandom);
            rdata = 16'($urandom);
            div = 8'($urandom_range(1));
            xfer(r);
        end
        bus_reset_req = 1'b1;
        repeat (2) @(negedge sys_clk);
        cmp("bus reset", 0, ctl_out[5]);
        bus_reset_req = 1'b0;
        sel = 6'h00;
        gpio_oe = 6'($urandom);
        gpio_out = 6'($urandom);
        repeat (3) @(negedge sys_clk);
        cmp("gpio out", gpio_out, ctl_out);
        cmp("gpio oe", gpio_oe, ctl_oe);
        cmp("gpio in", 6'(~gpio_oe), 6'(gpio_in & ~gpio_oe));
        summarize();
    end
endmodule
bind sbp_bus_port sbp_bus_port_props props (.sys_clk, .reset, .req, .req_ready,
    .bus_reset_req, .pin_bus_sel, .gpio_out, .gpio_oe, .addr_out, .sdram_clock_out,
    .ctl_out, .ctl_oe);
